// ---- drc_ctrl.sv ----
// Purpose: controller driving an asynchronous 4M x 4 page-mode dynamic memory
// Assumes: 25 MHz clock, synchronous reset, device pins sampled synchronously
// Notes: strobes come straight from flip-flops; one access at a time
// Behaviour
// - after power-up wait the pause, then eight refresh cycles before access
// - after a refresh-period violation repeat the eight wake-up cycles
// - pulse column strobe high before a new cycle to clear outputs
// - self refresh entry: column-first sequence, row low for entry width
// - self refresh exit: row strobe high for exit precharge time
// - standard device: refresh all 2048 rows within 32 ms
// - self-refresh variant: refresh period may stretch to 128 ms
// - on self entry keep column strobe low 15 ns after row falls
// - column-first refresh: column strobe low 5 ns before row falls
// - column-first refresh: write strobe high 10 ns around row fall
// - hidden refresh toggles row strobe with column low; output enable early (not done here: refresh is column-first from idle only)
// - row-only refresh cycles row strobe with column high, data floats
// - in page mode row strobe never stays low past page maximum
// - column accesses within a page spaced by page cycle time
// - new-row cycles start no closer than random cycle time
// - 11 row bits then 11 column bits over shared address pins
// - write strobe high reads, low writes
// - page mode keeps row low and toggles column; row high ends page
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"
module drc_ctrl
	import drc_pkg::*;
#(
	parameter bit SELF_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [21:0] req_addr,
	input wire logic [3:0] req_wdata,
	output logic rsp_valid,
	output logic [3:0] rsp_rdata,
	input wire logic self_enter,
	input wire logic self_leave,
	input wire logic refresh_lost,
	output logic init_done,
	output logic in_self,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic oe_n,
	output logic [10:0] mem_addr,
	input wire logic [3:0] shared_data_pins_i,
	output logic [3:0] shared_data_pins_o,
	output logic shared_data_pins_oe
);
	localparam logic [11:0] PWR_C = 12'(`DRC_PWR_CYC);
	localparam logic [11:0] RP_C = 12'(`DRC_TRP_CYC);
	localparam logic [11:0] RAS_C = 12'(`DRC_TRAS_CYC);
	localparam logic [11:0] CAS_C = 12'(`DRC_CAS_CYC); // column held past row access
	localparam logic [11:0] RASS_C = 12'(`DRC_SELF_REFRESH_ENTRY_WIDTH_CYC);
	localparam logic [11:0] RPS_C = 12'(`DRC_SELF_REFRESH_EXIT_PRECHARGE_CYC);
	localparam logic [11:0] RASP_C = 12'(`DRC_PAGE_ROW_WIDTH_MAX_CYC);
	localparam logic [11:0] REF_C = SELF_VARIANT ? 12'(`DRC_REF_EXT_CYC) : 12'(`DRC_REF_STD_CYC);
	localparam logic [3:0] WAKE_C = 4'(`DRC_WAKE_CNT);

	drc_state_e state_ff, nxt_state;
	logic [11:0] cnt_ff, nxt_cnt;
	logic [11:0] ref_cnt_ff;
	logic [11:0] ras_cnt_ff;
	logic [3:0] wake_ff;
	logic ref_pend_ff, wr_ff, nxt_wr, take, same_row, page_ok, self_ok;
	logic [21:0] areg_ff, nxt_areg;
	logic [3:0] wdata_ff;
	logic init_ff, rsp_ff;
	logic [3:0] rdata_ff;

	assign same_row = req_addr[21:11] == areg_ff[21:11];
	assign page_ok = (ras_cnt_ff < RASP_C - 12'h008) && !ref_pend_ff;
	assign self_ok = SELF_VARIANT && self_enter;

	// next state, counter and request take
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff + 12'h001;
		take = 1'b0;
		unique case (state_ff)
			ST_PWR: if (cnt_ff == PWR_C - 12'h001) begin
				nxt_state = ST_WAKE_RAS;
				nxt_cnt = 12'h000;
			end
			ST_WAKE_RAS: if (cnt_ff == RAS_C - 12'h001) begin
				nxt_state = ST_WAKE_PRE;
				nxt_cnt = 12'h000;
			end
			ST_WAKE_PRE: if (cnt_ff == RP_C - 12'h001) begin
				nxt_state = (wake_ff == WAKE_C - 4'h1) ? ST_IDLE : ST_WAKE_RAS;
				nxt_cnt = 12'h000;
			end
			ST_IDLE: begin
				nxt_cnt = 12'h000;
				if (refresh_lost) begin
					nxt_state = ST_WAKE_RAS;
				end else if (ref_pend_ff) begin
					nxt_state = ST_CBR_CAS;
				end else if (self_ok) begin
					nxt_state = ST_SELF_CAS;
				end else if (req_valid) begin
					take = 1'b1;
					nxt_state = ST_ROW;
				end
			end
			ST_ROW: begin
				nxt_state = ST_COL;
				nxt_cnt = 12'h000;
			end
			ST_COL: if (cnt_ff == CAS_C - 12'h001) begin
				nxt_cnt = 12'h000;
				if (page_ok && req_valid && same_row) begin
					take = 1'b1;
					nxt_state = ST_PAGE;
				end else begin
					nxt_state = ST_PRE;
				end
			end
			ST_PAGE: begin
				nxt_state = ST_COL;
				nxt_cnt = 12'h000;
			end
			ST_PRE: if (cnt_ff == RP_C - 12'h001) begin
				nxt_state = ST_IDLE;
				nxt_cnt = 12'h000;
			end
			ST_CBR_CAS: begin
				nxt_state = ST_CBR_RAS;
				nxt_cnt = 12'h000;
			end
			ST_CBR_RAS: if (cnt_ff == RAS_C - 12'h001) begin
				nxt_state = ST_PRE;
				nxt_cnt = 12'h000;
			end
			ST_SELF_CAS: begin
				nxt_state = ST_SELF;
				nxt_cnt = 12'h000;
			end
			ST_SELF: begin
				if (cnt_ff >= RASS_C - 12'h001) begin
					nxt_cnt = cnt_ff;
					if (self_leave) begin
						nxt_state = ST_SELF_EXIT;
						nxt_cnt = 12'h000;
					end
				end
			end
			ST_SELF_EXIT: if (cnt_ff == RPS_C - 12'h001) begin
				nxt_state = ST_IDLE;
				nxt_cnt = 12'h000;
			end
			default: begin
				nxt_state = ST_PWR;
				nxt_cnt = 12'h000;
			end
		endcase
		nxt_wr = take ? req_write : wr_ff;
		nxt_areg = take ? req_addr : areg_ff;
	end

	assign req_ready = take;

	// state, counter and request registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_PWR;
			cnt_ff <= 12'h000;
			wr_ff <= 1'b0;
			areg_ff <= 22'h000000;
			wdata_ff <= 4'h0;
		end else if (ce) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			wr_ff <= nxt_wr;
			areg_ff <= nxt_areg;
			if (take) begin
				wdata_ff <= req_wdata;
			end
		end
	end

	// wake-up cycle count and init flag
	always_ff @(posedge clk) begin
		if (reset) begin
			wake_ff <= 4'h0;
			init_ff <= 1'b0;
		end else if (ce) begin
			if (state_ff == ST_IDLE && refresh_lost) begin
				wake_ff <= 4'h0;
				init_ff <= 1'b0;
			end else if (state_ff == ST_WAKE_PRE && nxt_state != ST_WAKE_PRE) begin
				wake_ff <= wake_ff + 4'h1;
				init_ff <= nxt_state == ST_IDLE;
			end
		end
	end

	// distributed refresh timer; a new tick wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			ref_cnt_ff <= 12'h000;
			ref_pend_ff <= 1'b0;
		end else if (ce) begin
			if (ref_cnt_ff == REF_C - 12'h001 || state_ff == ST_SELF) begin
				ref_cnt_ff <= 12'h000;
			end else begin
				ref_cnt_ff <= ref_cnt_ff + 12'h001;
			end
			if (ref_cnt_ff == REF_C - 12'h001 && state_ff != ST_SELF) begin
				ref_pend_ff <= 1'b1;
			end else if (state_ff == ST_CBR_CAS) begin
				ref_pend_ff <= 1'b0;
			end
		end
	end

	// time the row strobe has been low, for the page limit; self refresh is no page
	always_ff @(posedge clk) begin
		if (reset) begin
			ras_cnt_ff <= 12'h000;
		end else if (ce) begin
			ras_cnt_ff <= (ras_n || state_ff == ST_SELF) ? 12'h000 : ras_cnt_ff + 12'h001;
		end
	end

	// device pins, registered from the next state
	always_ff @(posedge clk) begin
		if (reset) begin
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			mem_addr <= 11'h000;
			shared_data_pins_o <= 4'h0;
			shared_data_pins_oe <= 1'b0;
		end else if (ce) begin
			ras_n <= !(nxt_state inside {ST_WAKE_RAS, ST_ROW, ST_COL, ST_PAGE,
				ST_CBR_RAS, ST_SELF});
			cas_n <= !(nxt_state inside {ST_COL, ST_CBR_CAS, ST_CBR_RAS,
				ST_SELF_CAS, ST_SELF});
			we_n <= !(nxt_state inside {ST_ROW, ST_COL, ST_PAGE} && nxt_wr);
			oe_n <= !(nxt_state == ST_COL && !nxt_wr);
			if (nxt_state == ST_WAKE_RAS) begin
				mem_addr <= {7'h00, wake_ff};
			end else if (nxt_state == ST_ROW) begin
				mem_addr <= nxt_areg[21:11];
			end else if (nxt_state inside {ST_COL, ST_PAGE}) begin
				mem_addr <= nxt_areg[10:0];
			end
			shared_data_pins_o <= take ? req_wdata : wdata_ff;
			shared_data_pins_oe <= nxt_state == ST_COL && nxt_wr;
		end
	end

	// read data capture at the end of the column pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_ff <= 1'b0;
			rdata_ff <= 4'h0;
		end else if (ce) begin
			rsp_ff <= state_ff == ST_COL && cnt_ff == CAS_C - 12'h001 && !wr_ff;
			if (state_ff == ST_COL && cnt_ff == CAS_C - 12'h001 && !wr_ff) begin
				rdata_ff <= shared_data_pins_i;
			end
		end
	end

	assign rsp_valid = rsp_ff;
	assign rsp_rdata = rdata_ff;
	assign init_done = init_ff;
	assign in_self = state_ff == ST_SELF;

	// checks on the pin sequences
	default clocking dcb @(posedge clk iff ce);
	endclocking
	default disable iff (reset);

	sequence s_cbr_fall;
		!cas_n && $fell(ras_n);
	endsequence

	a_cbr_cas_lead: assert property (s_cbr_fall |-> $past(!cas_n))
		else $error("column strobe not low before row fall");
	a_cbr_we_high: assert property (s_cbr_fall |-> $past(we_n) && we_n ##1 we_n)
		else $error("write strobe not high around refresh row fall");
	a_dq_off_cas: assert property (shared_data_pins_oe |-> !cas_n && !we_n && oe_n)
		else $error("write data driven while device may drive");
	a_dq_after_cas_hi: assert property ($rose(shared_data_pins_oe) |-> $past(cas_n))
		else $error("write data not preceded by column high");
	a_precharge_len: assert property ($rose(ras_n) |-> ras_n [*2])
		else $error("row precharge too short");
	a_page_limit: assert property (ras_cnt_ff < RASP_C)
		else $error("row strobe low past page maximum");
	a_self_width: assert property (in_self && !$past(in_self) |-> !ras_n [*8])
		else $error("self refresh row low too short");
	a_self_cas_hold: assert property (in_self |-> !cas_n && !ras_n)
		else $error("column strobe released during self entry");
	a_self_exit: assert property ($fell(in_self) |-> ##1 ras_n [*4])
		else $error("self refresh exit precharge too short");
	a_wake_first: assert property ($fell(cas_n) && !ras_n |-> init_done)
		else $error("access before wake-up refresh done");
	a_wake_count: assert property ($rose(init_done) |-> wake_ff == WAKE_C)
		else $error("wrong number of wake-up refresh cycles");
	a_ras_only: assert property (state_ff == ST_WAKE_RAS |-> cas_n && !shared_data_pins_oe)
		else $error("row-only refresh with column low");
endmodule // drc_ctrl
`default_nettype wire

// ---- drc_regs.svh ----
// Purpose: timing figures and derived cycle counts for the memory controller
// Assumes: 40 ns clock; slower speed grade figures used throughout
// Notes: least times round up, longest times round down
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH
`define DRC_CLK_NS 40
`define DRC_CEIL(ns) (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_FLOOR(ns) ((ns) / `DRC_CLK_NS)
// power-up pause and wake-up refresh count
`define DRC_PWR_NS 100000
`define DRC_PWR_CYC `DRC_CEIL(`DRC_PWR_NS)
`define DRC_WAKE_CNT 8
// random cycle, row precharge, row pulse, column pulse
`define DRC_TRC_NS 130
`define DRC_TRC_CYC `DRC_CEIL(`DRC_TRC_NS)
`define DRC_TRP_NS 50
`define DRC_TRP_CYC `DRC_CEIL(`DRC_TRP_NS)
`define DRC_TRAS_NS 70
`define DRC_TRAS_CYC `DRC_CEIL(`DRC_TRAS_NS)
`define DRC_ROW_ACCESS_TIME_NS 70
`define DRC_CAS_CYC `DRC_CEIL(`DRC_ROW_ACCESS_TIME_NS)
`define DRC_TPC_NS 40
`define DRC_TPC_CYC `DRC_CEIL(`DRC_TPC_NS)
// page limit, self refresh entry and exit
`define DRC_PAGE_ROW_WIDTH_MAX_NS 100000
`define DRC_PAGE_ROW_WIDTH_MAX_CYC `DRC_FLOOR(`DRC_PAGE_ROW_WIDTH_MAX_NS)
`define DRC_SELF_REFRESH_ENTRY_WIDTH_NS 100000
`define DRC_SELF_REFRESH_ENTRY_WIDTH_CYC `DRC_CEIL(`DRC_SELF_REFRESH_ENTRY_WIDTH_NS)
`define DRC_SELF_REFRESH_EXIT_PRECHARGE_NS 130
`define DRC_SELF_REFRESH_EXIT_PRECHARGE_CYC `DRC_CEIL(`DRC_SELF_REFRESH_EXIT_PRECHARGE_NS)
// distributed refresh: period over 2048 rows, per-row interval
`define DRC_ROWS 2048
`define DRC_REFRESH_PERIOD_STD_NS 32000000
`define DRC_REFRESH_PERIOD_EXT_NS 128000000
`define DRC_REF_STD_CYC `DRC_FLOOR(`DRC_REFRESH_PERIOD_STD_NS / `DRC_ROWS)
`define DRC_REF_EXT_CYC `DRC_FLOOR(`DRC_REFRESH_PERIOD_EXT_NS / `DRC_ROWS)
// address split
`define DRC_AW 11
`define DRC_DW 4
`define DRC_ROW_LSB 11
`endif

// ---- drc_pkg.sv ----
// Purpose: types shared by the memory controller
// Assumes: nothing
// Notes: state codes written out
package drc_pkg;
	typedef enum logic [3:0] {
		ST_PWR = 4'h0,
		ST_WAKE_RAS = 4'h1,
		ST_WAKE_PRE = 4'h2,
		ST_IDLE = 4'h3,
		ST_ROW = 4'h4,
		ST_COL = 4'h5,
		ST_PAGE = 4'h6,
		ST_PRE = 4'h7,
		ST_CBR_CAS = 4'h8,
		ST_CBR_RAS = 4'h9,
		ST_SELF_CAS = 4'ha,
		ST_SELF = 4'hb,
		ST_SELF_EXIT = 4'hc
	} drc_state_e;
endpackage

// ---- drc_mem_model.sv ----
// Purpose: far-side model of the 4M x 4 page-mode memory
// Assumes: pins settle within 1 ns of a strobe edge; times in ns
// Notes: faults are counted in viol and never stop the run
`timescale 1ns/1ps
`default_nettype none
module drc_mem_model #(parameter bit SELF_VARIANT = 1'b0) (
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [10:0] addr,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic dq_drive,
	output int viol
);
	logic [3:0] mem [int];
	logic [10:0] row = '0;
	logic rd = 1'b0, column_first_refresh = 1'b0, was_self = 1'b0;
	int falls = 0;
	time t_ras = 0, t_rise = 0, t_cas = 0;
	initial viol = 0;
	// drive only a read in progress; float while column strobe is high
	assign dq_drive = rd && !cas_n && !oe_n;
	// row strobe falls: latch the row, or refresh from the internal counter
	always @(negedge ras_n) begin
		#1;
		column_first_refresh = !cas_n;
		if (column_first_refresh && we_n !== 1'b1) viol++;
		if (!column_first_refresh) row = addr;
		if ($time - t_ras < 130 || $time - t_rise < (was_self ? 130 : 50)) viol++;
		t_ras = $time;
		falls++;
	end
	// row strobe rises: only self refresh on the variant may stay low long
	always @(posedge ras_n) begin
		was_self = column_first_refresh && $time - t_ras >= 99999;
		if ($time - t_ras > 100000 && !(SELF_VARIANT && column_first_refresh)) viol++;
		t_rise = $time;
	end
	// column strobe falls under a low row strobe: one word is accessed
	always @(negedge cas_n) begin
		#1;
		if (!ras_n) begin
			if (falls < 8 || $time - t_cas < 40) viol++;
			t_cas = $time;
			if (!we_n) mem[{row, addr}] = dq_in;
			else dq_out = mem.exists({row, addr}) ? mem[{row, addr}] : 4'h0;
			#19;
			rd = we_n && !cas_n;
		end
	end
	// column strobe high ends any output
	always @(posedge cas_n) rd = 1'b0;
endmodule // drc_mem_model
`default_nettype wire

// ---- tb_async_dram_access_refresh.sv ----
// Purpose: self-checking bench of the memory controller with the memory model
// Assumes: 25 MHz clock; inputs change on the falling edge
// Notes: self-refresh variant, so self refresh and the long period are reached
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_async_dram_access_refresh;
	logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, prev_ras = 1'b1;
	logic self_enter = 1'b0, self_leave = 1'b0, refresh_lost = 1'b0;
	logic [21:0] req_addr = '0;
	logic [3:0] req_wdata = '0;
	logic [3:0] rsp_rdata, dq_out, pins_o, pins_in, q;
	logic req_ready, rsp_valid, init_done, in_self, ras_n, cas_n, we_n, oe_n, pins_oe, dq_drive;
	logic [10:0] mem_addr;
	logic [21:0] addrs [4] = '{22'h3ff800, 22'h3fffff, 22'h0007ff, 22'h000001};
	int err_count = 0, samples_checked = 0, cyc = 0, ras_only = 0, gap = 0, last_cbr = 0;
	int t0, viol;
	// clock and the resolved data lines; released lines change every cycle
	always #20 clk = ~clk;
	assign pins_in = pins_oe ? pins_o : (dq_drive ? dq_out : cyc[3:0] ^ 4'h5);
	drc_ctrl #(.SELF_VARIANT(1'b1)) dut (.clk(clk), .reset(reset), .ce(1'b1),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.self_enter(self_enter), .self_leave(self_leave), .refresh_lost(refresh_lost),
		.init_done(init_done), .in_self(in_self), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.oe_n(oe_n), .mem_addr(mem_addr), .shared_data_pins_i(pins_in),
		.shared_data_pins_o(pins_o), .shared_data_pins_oe(pins_oe));
	drc_mem_model #(.SELF_VARIANT(1'b1)) mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.oe_n(oe_n), .addr(mem_addr), .dq_in(pins_in), .dq_out(dq_out), .dq_drive(dq_drive),
		.viol(viol));
	// counts, verdict and end of run
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// bounded wait for a level
	task automatic wait_on(ref logic s, input logic v, input int lim);
		for (int n = 0; n < lim && s !== v; n++) @(negedge clk);
	endtask
	// one request held until taken; a read checks its pins and waits for data
	task automatic xfer(input logic wr, input logic [21:0] a, input logic [3:0] d, input logic keep);
		int n;
		n = 0;
		if (req_valid !== 1'b1) req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		#1;
		while (req_ready !== 1'b1 && n < 4000) begin
			@(negedge clk);
			#1;
			n++;
		end
		@(negedge clk);
		if (!keep) req_valid = 1'b0;
		if (!wr) begin
			`CHECK("row_addr", a[21:11], mem_addr)
			`CHECK("read_we", 1'b1, we_n)
			@(negedge clk);
			`CHECK("col_addr", a[10:0], mem_addr)
			`CHECK("read_oe", 1'b0, oe_n)
			for (n = 0; n < 8 && rsp_valid !== 1'b1; n++) @(negedge clk);
			q = rsp_rdata;
		end
	endtask
	// per cycle: timeout, refresh kinds and spacing, bus ownership
	always @(negedge clk) begin
		cyc++;
		if (prev_ras && !ras_n && cas_n) ras_only++;
		if (prev_ras && !ras_n && !cas_n) begin
			gap = cyc - last_cbr;
			last_cbr = cyc;
		end
		prev_ras = ras_n;
		`CHECK("bus_free", 1'b0, pins_oe & dq_drive)
		if (cyc == 15000) begin
			err_count++;
			summarize();
		end
	end
	// test sequence
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (2499) @(negedge clk);
		`CHECK("pause_quiet", 0, ras_only)
		`CHECK("pause_ready", 1'b0, req_ready)
		wait_on(init_done, 1'b1, 100);
		`CHECK("wake_done", 1'b1, init_done)
		`CHECK("wake_count", 8, ras_only)
		$display("test wake done");
		for (int i = 0; i < 4; i++) xfer(1'b1, addrs[i], 4'(i) ^ 4'ha, i < 3);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, addrs[i], 4'h0, 1'b0);
			`CHECK("read_data", 4'(i) ^ 4'ha, q)
		end
		$display("test access done");
		t0 = ras_only;
		refresh_lost = 1'b1;
		repeat (4) @(negedge clk);
		refresh_lost = 1'b0;
		repeat (60) @(negedge clk);
		`CHECK("rewake_count", 8, ras_only - t0)
		$display("test rewake done");
		self_enter = 1'b1;
		wait_on(in_self, 1'b1, 20);
		self_enter = 1'b0;
		self_leave = 1'b1;
		t0 = cyc;
		`CHECK("self_strobes", 2'b00, {ras_n, cas_n})
		wait_on(ras_n, 1'b1, 3000);
		`CHECK("self_width", 1'b1, cyc - t0 >= 2499)
		wait_on(in_self, 1'b0, 20);
		self_leave = 1'b0;
		xfer(1'b0, addrs[2], 4'h0, 1'b0);
		`CHECK("self_keep", 4'h8, q)
		$display("test self done");
		repeat (3300) @(negedge clk);
		`CHECK("ref_gap", 1'b1, gap > 1500 && gap <= 1562)
		`CHECK("model_faults", 0, viol)
		$display("test refresh done");
		summarize();
	end
endmodule // tb_async_dram_access_refresh
`default_nettype wire
